//--- shared/eec_pkg.sv
// Constants, register map and carrier types of the external event controller
package eec_pkg;
  localparam int NUM_LINES   = 19;
  localparam int NUM_EXT     = 16;
  localparam int NUM_INT     = 3;
  localparam int NUM_PINS    = 80;
  localparam int SEL_W       = 7;
  localparam int SEL_FIELD_W = 8;
  localparam int SEL_PER_REG = 4;
  localparam int SEL_REGS    = 4;
  localparam int ADR_W       = 8;
  localparam int DAT_W       = 32;
  localparam int SEL_BE_W    = 4;

  // Word-aligned byte addresses
  localparam logic [7:0] OFS_IRQ_MASK = 8'h00;
  localparam logic [7:0] OFS_EVT_MASK = 8'h04;
  localparam logic [7:0] OFS_RISE_EN  = 8'h08;
  localparam logic [7:0] OFS_FALL_EN  = 8'h0C;
  localparam logic [7:0] OFS_PENDING  = 8'h10;
  localparam logic [7:0] OFS_SEL0     = 8'h14;
  localparam logic [7:0] OFS_SEL_STEP = 8'h04;

  localparam logic [18:0] RST_LINES = 19'h00000;
  localparam logic [6:0]  RST_SEL   = 7'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

  // Bus clock figures: the register logic is one flop deep so it meets either
  localparam int BUS_MAX_MHZ = 72;
  localparam int CLK_MHZ     = 200;

  typedef logic [NUM_LINES-1:0] eec_line_t;

  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [ADR_W-1:0]    adr;
    logic [SEL_BE_W-1:0] sel;
    logic [DAT_W-1:0]    dat;
  } eec_wb_req_t;

  typedef struct packed {
    eec_line_t rise;
    eec_line_t fall;
  } eec_edge_t;
endpackage : eec_pkg

//--- verilog/eec_pin_mux.sv
// Pin selector feeding the sixteen external lines
`timescale 1ns/1ps
module eec_pin_mux #(
  parameter int NUM_PINS = eec_pkg::NUM_PINS,
  parameter int NUM_EXT  = eec_pkg::NUM_EXT,
  parameter int SEL_W    = eec_pkg::SEL_W
) (
  input  wire logic [NUM_PINS-1:0]         pins,
  input  wire logic [NUM_EXT-1:0][SEL_W-1:0] sel,
  output wire logic [NUM_EXT-1:0]          lines
);
  // Out-of-range index reads as a quiet low line
  function automatic logic pick(input logic [NUM_PINS-1:0] p, input logic [SEL_W-1:0] idx);
    logic r;
    r = 1'b0;
    if (int'(idx) < NUM_PINS) begin
      r = p[idx];
    end
    return r;
  endfunction : pick

  genvar i;
  generate
    for (i = 0; i < NUM_EXT; i++) begin : g_line
      assign lines[i] = pick(pins, sel[i]);
    end
  endgenerate
endmodule : eec_pin_mux

//--- verilog/eec_edge_catch.sv
// Asynchronous edge catchers with toggle crossing into the bus clock
`timescale 1ns/1ps
module eec_edge_catch #(
  parameter int W = eec_pkg::NUM_LINES
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] sig,
  output wire logic [W-1:0] rise,
  output wire logic [W-1:0] fall
);
  wire logic [W-1:0] rtog_w;
  wire logic [W-1:0] ftog_w;
  logic      [W-1:0] rs1_reg;
  logic      [W-1:0] rs2_reg;
  logic      [W-1:0] rs3_reg;
  logic      [W-1:0] fs1_reg;
  logic      [W-1:0] fs2_reg;
  logic      [W-1:0] fs3_reg;

  // The input itself clocks a toggle, so a pulse far narrower than the bus
  // period is still seen; two same-kind edges within one bus cycle
  // cancel and are lost, the price of a toggle crossing.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_tog
      // One flop per line and edge kind, so no vector has drivers in several clock domains
      logic rt_reg;
      logic ft_reg;
      always_ff @(posedge sig[i] or negedge rst_n) begin
        if (!rst_n) rt_reg <= 1'b0;
        else        rt_reg <= ~rt_reg;
      end
      always_ff @(negedge sig[i] or negedge rst_n) begin
        if (!rst_n) ft_reg <= 1'b0;
        else        ft_reg <= ~ft_reg;
      end
      assign rtog_w[i] = rt_reg;
      assign ftog_w[i] = ft_reg;
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rs1_reg, rs2_reg, rs3_reg} <= '0;
      {fs1_reg, fs2_reg, fs3_reg} <= '0;
    end else begin
      {rs3_reg, rs2_reg, rs1_reg} <= {rs2_reg, rs1_reg, rtog_w};
      {fs3_reg, fs2_reg, fs1_reg} <= {fs2_reg, fs1_reg, ftog_w};
    end
  end

  assign rise = rs2_reg ^ rs3_reg;
  assign fall = fs2_reg ^ fs3_reg;

  // Same-kind edges are spaced four cycles or more, so each catch is a single-cycle pulse
  a_rise_one_cyc: assert property (@(posedge clk) disable iff (!rst_n)
    (rise != '0) |=> ((rise & $past(rise)) == '0))
    else $error("rise event longer than one cycle");

  a_fall_one_cyc: assert property (@(posedge clk) disable iff (!rst_n)
    (fall != '0) |=> ((fall & $past(fall)) == '0))
    else $error("fall event longer than one cycle");
endmodule : eec_edge_catch

//--- verilog/eec_top.sv
// External edge event controller: pin select, edge catch, masks, pending, Wishbone
//
// Operation
// - Nineteen edge lines raise interrupt or event requests.
// - Per line: rising, falling or both edges.
// - Masked lines forward no requests; others unaffected.
// - Pending bit records each interrupt request; software reads.
// - Pulses narrower than bus period still caught.
// - Sixteen external lines selected from 80 pins.
// - Register logic correct up to 72 MHz.
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module eec_top (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [79:0] GPIO_IN,
  input  wire logic [2:0]  INT_SRC_IN,
  output wire logic [31:0] WB_DAT_O,
  output wire logic        WB_ACK,
  output wire logic [18:0] IRQ_OUT,
  output wire logic [18:0] EVT_OUT
);
  localparam int NL = eec_pkg::NUM_LINES;
  localparam int NE = eec_pkg::NUM_EXT;
  localparam int SW = eec_pkg::SEL_W;

  eec_pkg::eec_wb_req_t req;
  eec_pkg::eec_edge_t   edg;
  eec_pkg::eec_line_t   irq_mask_reg;
  eec_pkg::eec_line_t   evt_mask_reg;
  eec_pkg::eec_line_t   rise_en_reg;
  eec_pkg::eec_line_t   fall_en_reg;
  eec_pkg::eec_line_t   pend_reg;
  eec_pkg::eec_line_t   irq_reg;
  eec_pkg::eec_line_t   evt_reg;
  logic [NE-1:0][SW-1:0] sel_reg;
  logic                  ack_reg;
  logic [31:0]           dat_o_reg;

  wire logic [NE-1:0]    ext_lines;
  wire logic [NL-1:0]    all_lines;
  wire logic [NL-1:0]    rise_w;
  wire logic [NL-1:0]    fall_w;

  // Byte-lane merge of write data into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = wdat[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic eec_pkg::eec_line_t merge_line(input eec_pkg::eec_line_t old,
                                                   input logic [31:0] wdat, input logic [3:0] be);
    logic [31:0] m;
    m = merge({13'h0000, old}, wdat, be);
    return m[NL-1:0];
  endfunction : merge_line

  // Four select fields to a register word, seven used bits per byte
  function automatic logic [31:0] pack_sel(input logic [NE-1:0][SW-1:0] s, input int k);
    logic [31:0] r;
    r = 32'h00000000;
    for (int b = 0; b < eec_pkg::SEL_PER_REG; b++) begin
      r[8*b +: 8] = {1'b0, s[eec_pkg::SEL_PER_REG*k + b]};
    end
    return r;
  endfunction : pack_sel

  assign req = '{cyc: WB_CYC, stb: WB_STB, we: WB_WE, adr: WB_ADR, sel: WB_SEL, dat: WB_DAT_I};

  // Pin selector and edge catchers
  eec_pin_mux #(
    .NUM_PINS (eec_pkg::NUM_PINS),
    .NUM_EXT  (NE),
    .SEL_W    (SW)
  ) u_mux (
    .pins  (GPIO_IN),
    .sel   (sel_reg),
    .lines (ext_lines)
  );

  assign all_lines = {INT_SRC_IN, ext_lines};

  eec_edge_catch #(
    .W (NL)
  ) u_catch (
    .clk   (CLK),
    .rst_n (RESET_N),
    .sig   (all_lines),
    .rise  (rise_w),
    .fall  (fall_w)
  );

  assign edg = '{rise: rise_w, fall: fall_w};

  // Bus decode: one wait state, write commits on the edge that raises ack
  wire logic        take_w = req.cyc & req.stb & ~ack_reg;
  wire logic        wr_w   = take_w & req.we;
  wire logic [7:0]  wadr_w = {req.adr[7:2], 2'b00};
  wire logic        hit_imr_w  = wr_w && (wadr_w == eec_pkg::OFS_IRQ_MASK);
  wire logic        hit_emr_w  = wr_w && (wadr_w == eec_pkg::OFS_EVT_MASK);
  wire logic        hit_rise_w = wr_w && (wadr_w == eec_pkg::OFS_RISE_EN);
  wire logic        hit_fall_w = wr_w && (wadr_w == eec_pkg::OFS_FALL_EN);
  wire logic        hit_pend_w = wr_w && (wadr_w == eec_pkg::OFS_PENDING);
  wire logic [3:0]  hit_sel_w;

  genvar k;
  generate
    for (k = 0; k < eec_pkg::SEL_REGS; k++) begin : g_selhit
      assign hit_sel_w[k] = wr_w &&
        (wadr_w == eec_pkg::OFS_SEL0 + 8'(k) * eec_pkg::OFS_SEL_STEP);
    end
  endgenerate

  // Edge qualification and pending update
  wire eec_pkg::eec_line_t trig_w = (edg.rise & rise_en_reg) | (edg.fall & fall_en_reg);
  wire eec_pkg::eec_line_t clr_w  =
    hit_pend_w ? merge_line(eec_pkg::RST_LINES, req.dat, req.sel) : eec_pkg::RST_LINES;
  // A new edge in the clearing cycle keeps the bit set
  wire eec_pkg::eec_line_t pend_next = (pend_reg & ~clr_w) | (trig_w & irq_mask_reg);
  wire eec_pkg::eec_line_t evt_next  = trig_w & evt_mask_reg;
  wire eec_pkg::eec_line_t irq_next  = pend_next & irq_mask_reg;

  wire eec_pkg::eec_line_t irq_mask_next = hit_imr_w ?
    merge_line(irq_mask_reg, req.dat, req.sel) : irq_mask_reg;
  wire eec_pkg::eec_line_t evt_mask_next = hit_emr_w ?
    merge_line(evt_mask_reg, req.dat, req.sel) : evt_mask_reg;
  wire eec_pkg::eec_line_t rise_en_next  = hit_rise_w ?
    merge_line(rise_en_reg, req.dat, req.sel) : rise_en_reg;
  wire eec_pkg::eec_line_t fall_en_next  = hit_fall_w ?
    merge_line(fall_en_reg, req.dat, req.sel) : fall_en_reg;

  // Read mux; unmapped words read as zero and still acknowledge
  wire logic [31:0] rd_next =
    (wadr_w == eec_pkg::OFS_IRQ_MASK) ? {13'h0000, irq_mask_reg} :
    (wadr_w == eec_pkg::OFS_EVT_MASK) ? {13'h0000, evt_mask_reg} :
    (wadr_w == eec_pkg::OFS_RISE_EN)  ? {13'h0000, rise_en_reg}  :
    (wadr_w == eec_pkg::OFS_FALL_EN)  ? {13'h0000, fall_en_reg}  :
    (wadr_w == eec_pkg::OFS_PENDING)  ? {13'h0000, pend_reg}     :
    (wadr_w == eec_pkg::OFS_SEL0)     ? pack_sel(sel_reg, 0)      :
    (wadr_w == eec_pkg::OFS_SEL0 + eec_pkg::OFS_SEL_STEP) ? pack_sel(sel_reg, 1) :
    (wadr_w == eec_pkg::OFS_SEL0 + 8'h08) ? pack_sel(sel_reg, 2) :
    (wadr_w == eec_pkg::OFS_SEL0 + 8'h0C) ? pack_sel(sel_reg, 3) :
    eec_pkg::RD_UNMAPPED;

  // Single register stage everywhere keeps the paths short for either clock
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_reg   <= 1'b0;
      dat_o_reg <= 32'h00000000;
    end else begin
      ack_reg   <= take_w;
      dat_o_reg <= (take_w && !req.we) ? rd_next : 32'h00000000;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_mask_reg <= eec_pkg::RST_LINES;
      evt_mask_reg <= eec_pkg::RST_LINES;
      rise_en_reg  <= eec_pkg::RST_LINES;
      fall_en_reg  <= eec_pkg::RST_LINES;
    end else begin
      irq_mask_reg <= irq_mask_next;
      evt_mask_reg <= evt_mask_next;
      rise_en_reg  <= rise_en_next;
      fall_en_reg  <= fall_en_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_reg <= eec_pkg::RST_LINES;
      irq_reg  <= eec_pkg::RST_LINES;
      evt_reg  <= eec_pkg::RST_LINES;
    end else begin
      pend_reg <= pend_next;
      irq_reg  <= irq_next;
      evt_reg  <= evt_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NE; i++) begin : g_sel
      localparam int R = i / eec_pkg::SEL_PER_REG;
      localparam int B = i % eec_pkg::SEL_PER_REG;
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          sel_reg[i] <= eec_pkg::RST_SEL;
        end else if (hit_sel_w[R] && req.sel[B]) begin
          sel_reg[i] <= req.dat[eec_pkg::SEL_FIELD_W*B +: SW];
        end
      end
    end
  endgenerate

  assign WB_ACK   = ack_reg;
  assign WB_DAT_O = dat_o_reg;
  assign IRQ_OUT  = irq_reg;
  assign EVT_OUT  = evt_reg;

  // Checks
  sequence s_write_pend;
    hit_pend_w && (trig_w == '0);
  endsequence

  sequence s_pend_low;
    ((pend_reg & $past(clr_w)) == '0);
  endsequence

  a_pend_set_trig: assert property (@(posedge CLK) disable iff (!RESET_N)
    ((trig_w & irq_mask_reg) != '0) |=>
      ((pend_reg & $past(trig_w & irq_mask_reg)) == $past(trig_w & irq_mask_reg)))
    else $error("unmasked edge did not set pending");

  a_pend_clear_one: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_write_pend |=> s_pend_low)
    else $error("pending bit not cleared by a one");

  a_pend_hold_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    1'b1 |=> (($past(pend_reg) & ~$past(clr_w) & ~pend_reg) == '0))
    else $error("pending bit dropped without a clear");

  a_masked_no_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
    1'b1 |=> ((pend_reg & ~$past(pend_reg) & ~$past(irq_mask_reg)) == '0))
    else $error("masked line set pending");

  a_no_trig_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    1'b1 |=> ((pend_reg & ~$past(pend_reg) & ~($past(rise_en_reg) | $past(fall_en_reg))) == '0))
    else $error("line with no edge selected set pending");

  a_evt_pulse_src: assert property (@(posedge CLK) disable iff (!RESET_N)
    (edg.rise != '0) |=> (EVT_OUT == $past((edg.rise & rise_en_reg | edg.fall & fall_en_reg)
                                            & evt_mask_reg)))
    else $error("event output does not follow the qualified edge");

  a_irq_from_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
    ((pend_reg & irq_mask_reg) != '0) |=> ((IRQ_OUT & $past(irq_mask_reg & ~clr_w)) != '0)
                                          || ($past(pend_reg & irq_mask_reg & ~clr_w) == '0))
    else $error("pending unmasked line without interrupt");

  a_ack_single_cyc: assert property (@(posedge CLK) disable iff (!RESET_N)
    (WB_CYC && WB_STB && !WB_ACK) |=> WB_ACK ##1 !WB_ACK)
    else $error("bus ack not one cycle after request");
endmodule : eec_top

//--- sim/eec_pin_model.sv
// Pin-side model: general pins and the three internal sources
`timescale 1ns/1ps
module eec_pin_model (
  output logic [79:0] gpio,
  output logic [2:0]  int_src
);
  logic [82:0] lvl_reg = 83'h0;
  assign gpio    = lvl_reg[79:0];
  assign int_src = lvl_reg[82:80];
  task automatic flip(input int s);
    if (s < 83) lvl_reg[s] <= ~lvl_reg[s];
  endtask : flip
  // 2 ns excursion, well under one bus period, so sampling alone would miss it
  task automatic blip(input int s);
    flip(s);
    #2;
    flip(s);
  endtask : blip
endmodule : eec_pin_model

//--- sim/external_edge_event_controller_bench.sv
// Self-checking bench of the external event controller
`timescale 1ns/1ps
module external_edge_event_controller_bench;
  logic                 clk;
  logic                 reset_n;
  eec_pkg::eec_wb_req_t req;
  logic [31:0]          rdat;
  logic                 ack;
  logic [18:0]          irq;
  logic [18:0]          evt;
  logic [79:0]          gpio;
  logic [2:0]           int_src;
  logic [31:0]          mreg [0:8];
  logic [82:0]          lev;
  logic [31:0]          rng = 32'h10D12DD5;
  logic [31:0]          r;
  logic [31:0]          d;
  int                   mismatches = 0;
  int                   n_tests = 0;
  int                   evt_seen;
  int                   evt_other;
  int                   cur_line = 0;

  eec_top dut (.CLK(clk), .RESET_N(reset_n), .WB_CYC(req.cyc), .WB_STB(req.stb), .WB_WE(req.we),
    .WB_ADR(req.adr), .WB_SEL(req.sel), .WB_DAT_I(req.dat), .GPIO_IN(gpio), .INT_SRC_IN(int_src),
    .WB_DAT_O(rdat), .WB_ACK(ack), .IRQ_OUT(irq), .EVT_OUT(evt));
  eec_pin_model pins (.gpio(gpio), .int_src(int_src));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (evt[cur_line] === 1'b1) evt_seen++;
    if ((evt & ~(19'h1 << cur_line)) !== 19'h0) evt_other++;
  end

  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task chk_count(input string what, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_count

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Request held until ack is sampled; no cycle count is assumed
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s,
            output logic [31:0] q);
    int n;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: dd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    req <= '0;
    if (n >= 40) chk_count("ack wait", 1, 0);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s);
    logic [31:0] q;
    logic [31:0] m;
    int i;
    xfer(1'b1, a, dd, s, q);
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    i = a >> 2;
    if (i < 4) mreg[i] = ((mreg[i] & ~m) | (dd & m)) & 32'h0007FFFF;
    else if (i == 4) mreg[4] = mreg[4] & ~(dd & m);
    else if (i <= 8) mreg[i] = ((mreg[i] & ~m) | (dd & m)) & 32'h7F7F7F7F;
  endtask : wr

  task rd(input logic [7:0] a, input string what);
    logic [31:0] q;
    int i;
    xfer(1'b0, a, 32'h0, 4'hF, q);
    i = a >> 2;
    chk_word(what, (i <= 8) ? mreg[i] : eec_pkg::RD_UNMAPPED, q);
  endtask : rd

  task edge_test(input int line, input logic [1:0] mode, input logic im, input logic em,
                 input bit gl, input int pin);
    int s;
    bit hit;
    logic [31:0] b;
    b = 32'h1 << line;
    s = (line < 16) ? pin : 64 + line;
    if (line < 16) wr(eec_pkg::OFS_SEL0 + 8'(4 * (line / 4)), 32'(pin) << (8 * (line % 4)), 4'h1 << (line % 4));
    wr(eec_pkg::OFS_RISE_EN, mode[0] ? b : 32'h0, 4'hF);
    wr(eec_pkg::OFS_FALL_EN, mode[1] ? b : 32'h0, 4'hF);
    wr(eec_pkg::OFS_IRQ_MASK, im ? b : 32'h0, 4'hF);
    wr(eec_pkg::OFS_EVT_MASK, em ? b : 32'h0, 4'hF);
    wr(eec_pkg::OFS_PENDING, 32'h0007FFFF, 4'hF);
    cur_line = line;
    evt_seen = 0;
    evt_other = 0;
    if (s > 82) hit = 1'b0;
    else if (gl) hit = |mode;
    else hit = lev[s] ? mode[1] : mode[0];
    if (s < 83 && !gl) lev[s] = ~lev[s];
    if (gl) pins.blip(s);
    else pins.flip(s);
    repeat (8) @(posedge clk);
    if (hit && im) mreg[4][line] = 1'b1;
    rd(eec_pkg::OFS_PENDING, "pending after edge");
    chk_word("irq lines", mreg[4] & mreg[0], {13'h0, irq});
    chk_count("event pulses", (hit && em) ? 1 : 0, evt_seen);
    chk_count("other line events", 0, evt_other);
    wr(eec_pkg::OFS_PENDING, 32'h0, 4'hF);
    rd(eec_pkg::OFS_PENDING, "pending kept");
    wr(eec_pkg::OFS_PENDING, b, 4'hF);
    rd(eec_pkg::OFS_PENDING, "pending cleared");
    $display("test edge line %0d mode %0d done", line, mode);
  endtask : edge_test

  initial begin
    req = '0;
    reset_n = 1'b0;
    lev = 83'h0;
    for (int i = 0; i <= 8; i++) mreg[i] = 32'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i <= 8; i++) rd(8'(4 * i), "reset value");
    rd(8'h40, "unmapped read");
    for (int i = 0; i <= 8; i++) begin
      d = xs();
      r = xs();
      if (i != 4) wr(8'(4 * i), d, r[3:0]);
      rd(8'(4 * i), "register readback");
    end
    wr(8'h40, xs(), 4'hF);
    rd(8'h40, "unmapped after write");
    $display("test registers done");
    // All 19 lines in turn, then random ones; every fifth edge is a narrow pulse
    for (int i = 0; i < 30; i++) begin
      r = xs();
      edge_test((i < 19) ? i : r % 19, 2'(i % 3 + 1), i % 4 != 3, r[8] && i % 5 != 4, i % 5 == 4,
                (i == 7) ? 127 : (r >> 12) % 80);
    end
    give_verdict();
  end

  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule : external_edge_event_controller_bench
